//--- rtl/multipurpose_pin_function_mux.sv
// What this block does
// - the alarm pin is driven low while an alarm is asserted and released otherwise.
// - pin 0 may be a general pin, the internal clock output or the timer output.
// - after reset pin 1 drives the carrier-detect level out.
// - after reset pin 2 drives the uart transmit data out.
// - in spi-only mode pin 2 may drive the interrupt request.
// - after reset pin 3 is the uart receive input, which this block holds high while pin 3 is not in uart use.
// - pin 4 may be the spi data output, changing on rising serial clock edges while select is low.
// - in uart break mode pin 4 drives the interrupt request, once software has enabled its driver.
// - pin 4 stays released after reset until software enables its driver.
// - after reset pin 5 is spi data in, sampled on falling serial clock edges into a 24-bit register.
// - after reset pin 6 is the spi chip select, and shifting happens only while it is low.
// - while select is high the data output is released and data input is ignored.
// - any pin not driven by its function is released.
`default_nettype none
`include "pin_mux_map.svh"
module multipurpose_pin_function_mux (
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire pin_mux_pkg::pin_cfg_t   cfg_in,
  input  wire logic                    cfg_load,
  input  wire logic                    spi_only_mode,
  input  wire logic                    uart_break_mode,
  input  wire logic                    alarm_active,
  input  wire logic                    clk_1p2288,
  input  wire logic                    timer_out,
  input  wire logic                    carrier_detect,
  input  wire logic                    uart_tx_data,
  input  wire logic                    irq_active,
  input  wire logic [23:0]             sdo_word,
  input  wire logic [6:0]              gpio_out,
  input  wire logic [6:0]              gpio_oe,
  input  wire logic [6:0]              pin_in,
  input  wire logic                    sclk_pin,
  output logic [6:0]                   pin_out,
  output logic [6:0]                   pin_oe,
  output logic                         alarm_n_out,
  output logic                         alarm_n_oe,
  output logic                         uart_receive_input,
  output pin_mux_pkg::spi_word_t       spi_rx,
  output pin_mux_pkg::pin_cfg_t        cfg_state
);
  import pin_mux_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    pin_cfg_t    cfg;
    logic [2:0]  sclk_s1;
    logic [2:0]  sclk_s2;
    logic        sclk_d;
    logic [23:0] shift;
    logic [23:0] txsh;
    logic [4:0]  cnt;
    spi_word_t   rx;
    gpio_t       pins;
    logic        alarm_oe;
    logic        rxd;
    logic        rx_s1;
    logic        rx_s2;
  } state_t;

  localparam pin_cfg_t CFG_RST = '{p0_fn: `P0_FN_GPIO, p1_fn: `P1_FN_CD, p2_fn: `P2_FN_UART,
                                   p3_fn: `P3_FN_UART, p4_fn: `P4_FN_SDO, p4_oe_en: 1'b0,
                                   p56_fn: `P56_FN_SPI};

  state_t st_r;
  state_t st_nxt;

  logic sclk_q;
  logic cs_n_q;
  logic sdi_q;
  logic sclk_rise;
  logic sclk_fall;
  logic sel;

  // ****************************************************************
  // decoding shared by select and pin releases
  // ****************************************************************
  // pins 5 and 6 switch together, so one test covers both
  function automatic logic spi_pins_on(input pin_cfg_t c);
    return c.p56_fn == `P56_FN_SPI;
  endfunction

  // ****************************************************************
  // synchronisers and edges
  // ****************************************************************
  // synchronised serial clock, select and data in; only stage 2 is read
  assign sclk_q    = st_r.sclk_s2[0];
  assign cs_n_q    = st_r.sclk_s2[1];
  assign sdi_q     = st_r.sclk_s2[2];
  assign sel       = spi_pins_on(st_r.cfg) && !cs_n_q;
  assign sclk_rise = sclk_q && !st_r.sclk_d;
  assign sclk_fall = !sclk_q && st_r.sclk_d;

  always_comb begin
    st_nxt         = st_r;
    st_nxt.rx.valid = 1'b0;
    st_nxt.sclk_s1 = {pin_in[5], pin_in[6], sclk_pin};
    st_nxt.sclk_s2 = st_r.sclk_s1;
    st_nxt.sclk_d  = sclk_q;
    // uart receive pin is asynchronous as well
    st_nxt.rx_s1   = pin_in[3];
    st_nxt.rx_s2   = st_r.rx_s1;
    // only take new selections between frames so sdo never changes mid-word
    if (cfg_load && !sel) begin
      st_nxt.cfg = cfg_in;
    end
    // ****************************************************************
    // serial shifting
    // ****************************************************************
    if (!sel) begin
      st_nxt.cnt  = `CNT_RST;
      st_nxt.txsh = sdo_word;
    end else begin
      if (sclk_fall) begin
        st_nxt.shift = {st_r.shift[22:0], sdi_q};
        if (st_r.cnt == 5'(`SHIFT_BITS - 1)) begin
          st_nxt.cnt      = `CNT_RST;
          st_nxt.rx.word  = {st_r.shift[22:0], sdi_q};
          st_nxt.rx.valid = 1'b1;
        end else begin
          st_nxt.cnt = st_r.cnt + 5'h01;
        end
      end
      if (sclk_rise && st_r.cnt != `CNT_RST) begin
        st_nxt.txsh = {st_r.txsh[22:0], 1'b0};
      end
    end
    // ****************************************************************
    // pin outputs, registered so a change never glitches
    // ****************************************************************
    st_nxt.pins.out = gpio_out;
    st_nxt.pins.oe  = 7'h00;
    case (st_r.cfg.p0_fn)
      `P0_FN_CLKOUT: begin
        st_nxt.pins.out[0] = clk_1p2288;
        st_nxt.pins.oe[0]  = 1'b1;
      end
      `P0_FN_TIMER: begin
        st_nxt.pins.out[0] = timer_out;
        st_nxt.pins.oe[0]  = 1'b1;
      end
      default: st_nxt.pins.oe[0] = gpio_oe[0];
    endcase
    if (st_r.cfg.p1_fn == `P1_FN_CD) begin
      st_nxt.pins.out[1] = carrier_detect;
      st_nxt.pins.oe[1]  = 1'b1;
    end else begin
      st_nxt.pins.oe[1] = gpio_oe[1];
    end
    case (st_r.cfg.p2_fn)
      `P2_FN_UART: begin
        st_nxt.pins.out[2] = uart_tx_data;
        st_nxt.pins.oe[2]  = 1'b1;
      end
      `P2_FN_IRQ: begin
        st_nxt.pins.out[2] = irq_active;
        st_nxt.pins.oe[2]  = spi_only_mode;
      end
      default: st_nxt.pins.oe[2] = gpio_oe[2];
    endcase
    st_nxt.pins.oe[3] = (st_r.cfg.p3_fn == `P3_FN_GPIO) && gpio_oe[3];
    if (st_r.cfg.p4_oe_en) begin
      if (uart_break_mode) begin
        st_nxt.pins.out[4] = irq_active;
        st_nxt.pins.oe[4]  = 1'b1;
      end else begin
        case (st_r.cfg.p4_fn)
          `P4_FN_SDO: begin
            st_nxt.pins.out[4] = st_nxt.txsh[23];
            st_nxt.pins.oe[4]  = sel;
          end
          `P4_FN_IRQ: begin
            st_nxt.pins.out[4] = irq_active;
            st_nxt.pins.oe[4]  = 1'b1;
          end
          default: st_nxt.pins.oe[4] = gpio_oe[4];
        endcase
      end
    end
    st_nxt.pins.oe[5] = !spi_pins_on(st_r.cfg) && gpio_oe[5];
    st_nxt.pins.oe[6] = !spi_pins_on(st_r.cfg) && gpio_oe[6];
    st_nxt.alarm_oe   = alarm_active;
    st_nxt.rxd        = (st_r.cfg.p3_fn == `P3_FN_UART) ? st_r.rx_s2 : 1'b1;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r          <= '0;
      st_r.cfg      <= CFG_RST;
      st_r.sclk_s1  <= `SYNC_RST;
      st_r.sclk_s2  <= `SYNC_RST;
      // idle high, so the uart sees no start bit coming out of reset
      st_r.rx_s1    <= 1'b1;
      st_r.rx_s2    <= 1'b1;
      st_r.shift    <= `SHIFT_RST;
      st_r.txsh     <= `SDO_LOAD_RST;
      st_r.rxd      <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign pin_out            = st_r.pins.out;
  assign pin_oe             = st_r.pins.oe;
  // open drain: only the enable ever moves
  assign alarm_n_out        = 1'b0;
  assign alarm_n_oe         = st_r.alarm_oe;
  assign uart_receive_input = st_r.rxd;
  assign spi_rx             = st_r.rx;
  assign cfg_state          = st_r.cfg;
endmodule
`default_nettype wire

//--- rtl/pin_mux_map.svh
`ifndef PIN_MUX_MAP_SVH
`define PIN_MUX_MAP_SVH
// ****************************************************************
// pin function codes
// ****************************************************************
`define P0_FN_GPIO    2'h0
`define P0_FN_CLKOUT  2'h1
`define P0_FN_TIMER   2'h2
`define P1_FN_CD      1'h0
`define P1_FN_GPIO    1'h1
`define P2_FN_UART    2'h0
`define P2_FN_GPIO    2'h1
`define P2_FN_IRQ     2'h2
`define P3_FN_UART    1'h0
`define P3_FN_GPIO    1'h1
`define P4_FN_SDO     2'h0
`define P4_FN_GPIO    2'h1
`define P4_FN_IRQ     2'h2
`define P56_FN_SPI    1'h0
`define P56_FN_GPIO   1'h1
// ****************************************************************
// sizes and reset values
// ****************************************************************
`define SHIFT_BITS    24
`define SHIFT_RST     24'h00_0000
`define SDO_LOAD_RST  24'h00_0000
`define CNT_RST       5'h00
// sync vector {sdi, cs_n, sclk}: idle levels, so reset leaves no false clock edge
`define SYNC_RST      3'h2
`endif

//--- rtl/pin_mux_pkg.sv
`default_nettype none
`include "pin_mux_map.svh"
package pin_mux_pkg;
  typedef struct packed {
    logic [1:0] p0_fn;
    logic       p1_fn;
    logic [1:0] p2_fn;
    logic       p3_fn;
    logic [1:0] p4_fn;
    logic       p4_oe_en;
    logic       p56_fn;
  } pin_cfg_t;

  typedef struct packed {
    logic [6:0] out;
    logic [6:0] oe;
  } gpio_t;

  typedef struct packed {
    logic [23:0] word;
    logic        valid;
  } spi_word_t;
endpackage
`default_nettype wire

//--- verif/host_model.sv
`default_nettype none
module host_model (
  input  wire logic        go,
  input  wire logic        sdo,
  output var  logic        cs_n,
  output var  logic        sclk,
  output var  logic        sdi,
  output var  logic [23:0] sent,
  output var  logic [23:0] got
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // one 24-bit frame per rise of go
  // ****
  initial begin
    cs_n = 1'h1;
    sdi = 1'h0;
    sclk = 1'h0;
  end
  // sclk only toggles inside a frame, sdi falls to its pull-down outside
  // edges kept off the system clock edges to avoid sampling races
  always @(posedge go) begin
    #5 cs_n = 1'h0;
    repeat (24) begin
      #100 sclk = 1'h1;
      sdi = 1'($urandom);
      sent = {sent[22:0], sdi};
      #100 got = {got[22:0], sdo};
      sclk = 1'h0;
    end
    #100 cs_n = 1'h1;
    sdi = 1'h0;
  end
endmodule
`default_nettype wire

//--- verif/pin_mux_monitor.sv
`default_nettype none
`include "pin_mux_map.svh"
module pin_mux_monitor (
  input wire logic                  mclk,
  input wire logic                  sys_rst,
  input wire logic                  cfg_load,
  input wire logic                  uart_break_mode,
  input wire logic                  alarm_active,
  input wire logic                  carrier_detect,
  input wire logic                  uart_tx_data,
  input wire logic [6:0]            pin_in,
  input wire logic [6:0]            pin_out,
  input wire logic [6:0]            pin_oe,
  input wire logic                  alarm_n_out,
  input wire logic                  alarm_n_oe,
  input wire logic                  uart_receive_input,
  input wire pin_mux_pkg::pin_cfg_t cfg_state
);
  import pin_mux_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  alarm_sink_a: assert property (!sys_rst |=> alarm_n_oe == $past(alarm_active) && !alarm_n_out)
    else $error("alarm pin wrong");
  sdo_idle_a: assert property ((pin_in[6] && !uart_break_mode && cfg_state.p4_fn == `P4_FN_SDO
    && cfg_state.p56_fn == `P56_FN_SPI)[*4] |-> !pin_oe[4]) else $error("sdo driven while idle");
  p4_off_a: assert property ((!cfg_state.p4_oe_en && !uart_break_mode
    && cfg_state.p4_fn == `P4_FN_SDO)[*2] |-> !pin_oe[4]) else $error("pin 4 driven unenabled");
  inputs_free_a: assert property ((cfg_state.p56_fn == `P56_FN_SPI && cfg_state.p3_fn == `P3_FN_UART)[*2]
    |-> !pin_oe[6] && !pin_oe[5] && !pin_oe[3]) else $error("input pin driven");
  cd_out_a: assert property ((cfg_state.p1_fn == `P1_FN_CD && $stable(carrier_detect))[*4]
    |-> pin_oe[1] && pin_out[1] == carrier_detect) else $error("carrier pin wrong");
  tx_out_a: assert property ((cfg_state.p2_fn == `P2_FN_UART && $stable(uart_tx_data))[*4]
    |-> pin_oe[2] && pin_out[2] == uart_tx_data) else $error("tx pin wrong");
  rx_follow_a: assert property ((cfg_state.p3_fn == `P3_FN_UART && $stable(pin_in[3]))[*5]
    |-> uart_receive_input == pin_in[3]) else $error("rx input wrong");
  cfg_hold_a: assert property (!cfg_load |=> $stable(cfg_state)) else $error("cfg moved");
  cover property (cfg_load);
  cover property (!pin_in[6] && pin_oe[4]);
  cover property (uart_break_mode && pin_oe[4]);
endmodule
bind multipurpose_pin_function_mux pin_mux_monitor mon_u (.mclk, .sys_rst, .cfg_load, .uart_break_mode,
  .alarm_active, .carrier_detect, .uart_tx_data, .pin_in, .pin_out, .pin_oe, .alarm_n_out, .alarm_n_oe,
  .uart_receive_input, .cfg_state);
`default_nettype wire

//--- verif/multipurpose_pin_function_mux_tb_top.sv
`default_nettype none
`include "pin_mux_map.svh"
module multipurpose_pin_function_mux_tb_top;
  import pin_mux_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 0, sys_rst = 1, cfg_load = 0, spi_only_mode = 0, uart_break_mode = 0, go = 0;
  logic        alarm_active, clk_1p2288, timer_out, carrier_detect, uart_tx_data, irq_active;
  logic        cs_n, sclk, sdi, alarm_n_out, alarm_n_oe, uart_receive_input;
  logic [23:0] sdo_word, sent, got, sdo_exp;
  logic [6:0]  gpio_out, gpio_oe, pin_out, pin_oe;
  logic [4:0]  pin_lo;
  wire  [6:0]  pin_in = {cs_n, sdi, pin_lo};
  pin_cfg_t    cfg_in = '0, cfg_state, c;
  spi_word_t   spi_rx;
  int          miscompares = 0, compares = 0, cyc = 0, nvalid = 0;
  multipurpose_pin_function_mux dut_u (.mclk, .sys_rst, .cfg_in, .cfg_load, .spi_only_mode, .uart_break_mode,
    .alarm_active, .clk_1p2288, .timer_out, .carrier_detect, .uart_tx_data, .irq_active, .sdo_word, .gpio_out,
    .gpio_oe, .pin_in, .sclk_pin(sclk), .pin_out, .pin_oe, .alarm_n_out, .alarm_n_oe, .uart_receive_input, .spi_rx,
    .cfg_state);
  // released sdo reads as its pull-up
  host_model host_u (.go, .sdo(pin_oe[4] ? pin_out[4] : 1'b1), .cs_n, .sclk, .sdi, .sent, .got);
  always @(posedge mclk) if (spi_rx.valid === 1'b1) nvalid++;
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 3000) begin
    miscompares++;
    print_verdict();
  end
  task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task print_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****
  // stimulus helpers
  // ****
  task cfg(input pin_cfg_t v);
    @(posedge mclk) cfg_in <= v;
    cfg_load <= 1;
    @(posedge mclk) cfg_load <= 0;
  endtask
  // sources held still long enough for the 1-3 cycle pin latency
  task rnd;
    @(posedge mclk) {alarm_active, clk_1p2288, timer_out, carrier_detect, uart_tx_data, irq_active} <= 6'($urandom);
    {gpio_out, gpio_oe, pin_lo} <= 19'($urandom);
    sdo_word <= 24'($urandom);
    repeat (7) @(posedge mclk);
  endtask
  function logic [1:0] p0_exp(logic [1:0] f);
    if (f == `P0_FN_GPIO) return {gpio_out[0], gpio_oe[0]};
    return {f == `P0_FN_CLKOUT ? clk_1p2288 : timer_out, 1'h1};
  endfunction
  // ****
  // tests
  // ****
  initial begin
    void'($urandom(21));
    rnd;
    sys_rst <= 0;
    for (int r = 0; r < 2; r++) begin
      rnd;
      chk("cfg_state", cfg_state, 10'h000);
      chk("pin4_oe", pin_oe[4], 1'h0);
      chk("in_oe", {pin_oe[6:5], pin_oe[3]}, 3'h0);
      chk("pin1", {pin_out[1], pin_oe[1]}, {carrier_detect, 1'h1});
      chk("pin2", {pin_out[2], pin_oe[2]}, {uart_tx_data, 1'h1});
      chk("rx", uart_receive_input, pin_in[3]);
      chk("alarm", {alarm_n_out, alarm_n_oe}, {1'h0, alarm_active});
      $display("defaults test done");
      for (int f = 0; f < 3; f++) begin
        c = '0;
        c.p0_fn = 2'(f);
        cfg(c);
        repeat (3) begin
          rnd;
          chk("pin0", {pin_out[0], pin_oe[0]}, p0_exp(c.p0_fn));
        end
      end
      c.p2_fn = `P2_FN_IRQ;
      c.p4_oe_en = 1;
      spi_only_mode <= 1;
      cfg(c);
      rnd;
      chk("pin2_irq", {pin_out[2], pin_oe[2]}, {irq_active, 1'h1});
      chk("sdo_idle", pin_oe[4], 1'h0);
      go <= 1;
      sdo_exp = sdo_word;
      repeat (20) @(posedge mclk);
      chk("sdo_on", pin_oe[4], 1'h1);
      cfg(~c);
      rnd;
      chk("cfg_lock", cfg_state, c);
      repeat (200) @(posedge mclk);
      chk("rx_word", spi_rx.word, sent);
      chk("rx_count", 24'(nvalid), 24'(r + 1));
      chk("sdo_data", got, sdo_exp);
      chk("sdo_rel", pin_oe[4], 1'h0);
      go <= 0;
      uart_break_mode <= 1;
      rnd;
      chk("pin4_irq", {pin_out[4], pin_oe[4]}, {irq_active, 1'h1});
      $display("function test done");
      sys_rst <= 1;
      uart_break_mode <= 0;
      spi_only_mode <= 0;
      rnd;
      sys_rst <= 0;
    end
    print_verdict();
  end
endmodule
`default_nettype wire
